// ---- scs_spi_ctrl.sv ----
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "scs_map.svh"
module scs_spi_ctrl #(
  parameter int NCS = 4
) (
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 irq,
  output logic                 sck_o,
  output logic                 sck_oe,
  output logic                 mosi_o,
  output logic                 mosi_oe,
  input  wire logic            miso_i,
  output logic      [NCS-1:0]  cs_n_o,
  output logic                 cs_oe
);
  localparam int CSW = $clog2(NCS);

  scs_pkg::scs_state_t st_q, st_d;
  logic             en_q, en_d, dis_q, dis_d;
  logic             tx_empty_flag_q, tx_empty_flag_d, last_q, last_d, xlast_q, xlast_d;
  logic [7:0]       thr_q, thr_d, sh_q, sh_d, rdr_q, rdr_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [CSW-1:0]   tcs_q, tcs_d, cur_q, cur_d;
  logic [NCS-1:0]   hold_q, hold_d;
  logic [NCS-1:0][7:0] dly_q, dly_d, div_q, div_d;
  logic [1:0]       mask_q, mask_d, stat_q, stat_d;
  logic [2:0]       bit_q, bit_d;
  logic             act_q, act_d, sck_q, sck_d, rxb_q, rxb_d;
  logic             miso_s1, miso_s2;
  logic [31:0]      prdata_q, prdata_d, rd_data;
  logic             pready_q, pready_d, pslverr_q, pslverr_d;
  logic             irq_q, irq_d, oe_q, mosi_q;
  logic             acc, wr, rd_stat, addr_ok, fin, load;
  logic             ev_empty, ev_done;
  logic [CSW-1:0]   cfg_idx;

  function automatic logic [7:0] half_m1(input logic [7:0] d);
    return (d == 8'h00) ? 8'h00 : d - 8'h01;
  endfunction : half_m1

  assign acc     = psel && penable && pready_q;
  assign wr      = acc && pwrite;
  assign rd_stat = acc && !pwrite && (paddr == `SCS_ADDR_STAT);
  assign cfg_idx = paddr[CSW+1:2];

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == `SCS_ADDR_CTL) begin
      rd_data = 32'h0000_0000;
    end else if (paddr == `SCS_ADDR_STAT) begin
      rd_data[1:0] = stat_q;
      rd_data[`SCS_ST_EMPTY] = tx_empty_flag_q;
      rd_data[`SCS_ST_EN] = en_q;
      rd_data[`SCS_ST_ACT] = act_q;
    end else if (paddr == `SCS_ADDR_MASK) begin
      rd_data[1:0] = mask_q;
    end else if (paddr == `SCS_ADDR_TXD) begin
      rd_data[7:0] = thr_q;
      rd_data[`SCS_TXD_CS_LSB +: CSW] = tcs_q;
    end else if (paddr == `SCS_ADDR_RXD) begin
      rd_data[7:0] = rdr_q;
    end else if (paddr[7:4] == `SCS_ADDR_CFG >> 4 && paddr[1:0] == 2'h0
                 && int'(cfg_idx) < NCS) begin
      rd_data[`SCS_CFG_HOLD] = hold_q[cfg_idx];
      rd_data[`SCS_CFG_DIV_LSB +: 8] = div_q[cfg_idx];
      rd_data[`SCS_CFG_DLY_LSB +: 8] = dly_q[cfg_idx];
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    en_d = en_q;
    dis_d = dis_q;
    tx_empty_flag_d = tx_empty_flag_q;
    last_d = last_q;
    xlast_d = xlast_q;
    thr_d = thr_q;
    sh_d = sh_q;
    rdr_d = rdr_q;
    cnt_d = cnt_q;
    tcs_d = tcs_q;
    cur_d = cur_q;
    hold_d = hold_q;
    dly_d = dly_q;
    div_d = div_q;
    mask_d = mask_q;
    bit_d = bit_q;
    act_d = act_q;
    sck_d = sck_q;
    rxb_d = rxb_q;
    fin = 1'b0;
    load = 1'b0;
    ev_empty = 1'b0;
    ev_done = 1'b0;
    unique case (st_q)
      scs_pkg::SCS_IDLE: begin
        if (dis_q) begin
          en_d = 1'b0;
          dis_d = 1'b0;
          act_d = 1'b0;
        end else if (act_q && xlast_q) begin
          act_d = 1'b0;
          xlast_d = 1'b0;
        end else if (en_q && !tx_empty_flag_q) begin
          if (act_q && cur_q != tcs_q) begin
            act_d = 1'b0;
          end else begin
            load = 1'b1;
          end
        end
      end
      scs_pkg::SCS_SHIFT: begin
        if (cnt_q == 8'h00) begin
          cnt_d = half_m1(div_q[cur_q]);
          sck_d = !sck_q;
          if (!sck_q) begin
            rxb_d = miso_s2;
          end else begin
            sh_d = {sh_q[6:0], rxb_q};
            bit_d = bit_q + 3'h1;
            fin = (bit_q == 3'h7);
          end
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      scs_pkg::SCS_GAP: begin
        if (dis_q) begin
          st_d = scs_pkg::SCS_IDLE;
          act_d = 1'b0;
        end else if (cnt_q == 8'h00) begin
          load = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
    if (fin) begin
      ev_done = 1'b1;
      rdr_d = {sh_q[6:0], rxb_q};
      st_d = scs_pkg::SCS_IDLE;
      if (dis_q) begin
        act_d = 1'b0;
      end else if (xlast_q) begin
        act_d = 1'b0;
        xlast_d = 1'b0;
      end else if (!tx_empty_flag_q && tcs_q == cur_q) begin
        st_d = scs_pkg::SCS_GAP;
        cnt_d = dly_q[cur_q];
      end else if (!tx_empty_flag_q) begin
        act_d = 1'b0;
      end else begin
        act_d = hold_q[cur_q];
      end
    end
    if (load) begin
      st_d = scs_pkg::SCS_SHIFT;
      sh_d = thr_q;
      cur_d = tcs_q;
      act_d = 1'b1;
      tx_empty_flag_d = 1'b1;
      ev_empty = 1'b1;
      xlast_d = last_q;
      last_d = 1'b0;
      bit_d = 3'h0;
      sck_d = 1'b0;
      cnt_d = half_m1(div_q[tcs_q]);
    end
    if (wr) begin
      if (paddr == `SCS_ADDR_CTL) begin
        if (pwdata[`SCS_CTL_DIS]) begin
          dis_d = 1'b1;
        end else if (pwdata[`SCS_CTL_EN]) begin
          en_d = 1'b1;
        end
        if (pwdata[`SCS_CTL_LAST]) begin
          if (tx_empty_flag_d) begin
            xlast_d = 1'b1;
          end else begin
            last_d = 1'b1;
          end
        end
      end else if (paddr == `SCS_ADDR_MASK) begin
        mask_d = pwdata[1:0];
      end else if (paddr == `SCS_ADDR_TXD) begin
        thr_d = pwdata[7:0];
        tcs_d = pwdata[`SCS_TXD_CS_LSB +: CSW];
        tx_empty_flag_d = 1'b0;
      end else if (addr_ok && paddr[7:4] == `SCS_ADDR_CFG >> 4) begin
        hold_d[cfg_idx] = pwdata[`SCS_CFG_HOLD];
        div_d[cfg_idx] = pwdata[`SCS_CFG_DIV_LSB +: 8];
        dly_d[cfg_idx] = pwdata[`SCS_CFG_DLY_LSB +: 8];
      end
    end
    stat_d = stat_q & ~(rd_stat ? prdata_q[1:0] : 2'h0);
    stat_d = stat_d | {ev_done, ev_empty};
    irq_d = |(stat_d & mask_d);
    pready_d = psel && penable && !pready_q;
    prdata_d = pready_d && !pwrite ? rd_data : prdata_q;
    pslverr_d = pready_d ? !addr_ok : 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= scs_pkg::SCS_IDLE;
      en_q <= 1'b0;
      dis_q <= 1'b0;
      tx_empty_flag_q <= 1'b1;
      last_q <= 1'b0;
      xlast_q <= 1'b0;
      thr_q <= 8'h00;
      sh_q <= 8'h00;
      rdr_q <= 8'h00;
      cnt_q <= 8'h00;
      tcs_q <= '0;
      cur_q <= '0;
      hold_q <= '0;
      dly_q <= {NCS{`SCS_DLY_RST}};
      div_q <= {NCS{`SCS_DIV_RST}};
      mask_q <= 2'h0;
      stat_q <= 2'h0;
      bit_q <= 3'h0;
      act_q <= 1'b0;
      sck_q <= 1'b0;
      rxb_q <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      oe_q <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      st_q <= st_d;
      en_q <= en_d;
      dis_q <= dis_d;
      tx_empty_flag_q <= tx_empty_flag_d;
      last_q <= last_d;
      xlast_q <= xlast_d;
      thr_q <= thr_d;
      sh_q <= sh_d;
      rdr_q <= rdr_d;
      cnt_q <= cnt_d;
      tcs_q <= tcs_d;
      cur_q <= cur_d;
      hold_q <= hold_d;
      dly_q <= dly_d;
      div_q <= div_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      bit_q <= bit_d;
      act_q <= act_d;
      sck_q <= sck_d;
      rxb_q <= rxb_d;
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      oe_q <= en_d;
      mosi_q <= sh_d[7];
    end
  end

  for (genvar i = 0; i < NCS; i++) begin : g_cs
    logic csn_d;
    assign csn_d = !(act_d && cur_d == CSW'(i));
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        cs_n_o[i] <= 1'b1;
      end else begin
        cs_n_o[i] <= csn_d;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign sck_o   = sck_q;
  assign mosi_o  = mosi_q;
  assign sck_oe  = oe_q;
  assign mosi_oe = oe_q;
  assign cs_oe   = oe_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_load_flag: assert property ($rose(st_q == scs_pkg::SCS_SHIFT)
    |-> tx_empty_flag_q && stat_q[0] || wr) else $error("no empty flag");
  a_gap_keep_cs: assert property (st_q == scs_pkg::SCS_GAP |-> act_q)
    else $error("select dropped in gap");
  a_gap_wait: assert property (st_q == scs_pkg::SCS_GAP && cnt_q != 8'h00
    && !dis_q |=> st_q == scs_pkg::SCS_GAP) else $error("gap short");
  a_hold_no_data: assert property (fin && tx_empty_flag_q && hold_q[cur_q]
    && !xlast_q && !dis_q && !wr |=> act_q ##1 (act_q || !tx_empty_flag_q))
    else $error("held select dropped");
  a_last_release: assert property (fin && xlast_q |=> !act_q)
    else $error("final not released");
  a_no_hold_drop: assert property (fin && tx_empty_flag_q && !hold_q[cur_q]
    |=> !act_q) else $error("select not dropped");
  a_dis_finish: assert property (fin && dis_q |=> st_q ==
    scs_pkg::SCS_IDLE ##1 !en_q ##1 !cs_oe) else $error("bad disable");
  a_both_dis: assert property (wr && paddr == `SCS_ADDR_CTL
    && pwdata[1:0] == 2'h3 |=> dis_q || !en_q)
    else $error("both bits enabled");
  a_enable_cmd: assert property (wr && paddr == `SCS_ADDR_CTL
    && pwdata[1:0] == 2'h1 && !dis_q |=> en_q ##1 sck_oe)
    else $error("enable ignored");
  c_gap: cover property (st_q == scs_pkg::SCS_GAP ##1
    st_q == scs_pkg::SCS_SHIFT);
  c_hold: cover property (fin && hold_q[cur_q] && tx_empty_flag_q ##1 act_q);
  c_dis_mid: cover property (st_q == scs_pkg::SCS_SHIFT && dis_q ##[1:400]
    !en_q);
endmodule : scs_spi_ctrl

// ---- scs_map.svh ----
// How it works
// - tx_empty_flag rises when the holding word is moved into the shifter.
// - pending data for the same chip select keeps that select asserted.
// - a per-select inter_transfer_delay is inserted only when the next word for the same select is already pending at the end of a transfer.
// - with cs_hold_after_transfer set the select stays until another is used.
// - with the hold bit set the select stays even with no new data.
// - final_transfer_cmd after the last word releases the select at its end.
// - with the hold bit clear the select may drop when no data is pending.
// - port_disable_cmd sets all pins to input once the transfer completes.
// - a disable mid-transfer finishes the shifter and starts nothing more.
// - enable and disable written together leave the port disabled.
// - writing 1 to port_enable_cmd enables; writing 0 has no effect.
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_ADDR_CTL      8'h00
`define SCS_ADDR_STAT     8'h04
`define SCS_ADDR_MASK     8'h08
`define SCS_ADDR_TXD      8'h0C
`define SCS_ADDR_RXD      8'h10
`define SCS_ADDR_CFG      8'h20
`define SCS_CTL_EN        0
`define SCS_CTL_DIS       1
`define SCS_CTL_LAST      24
`define SCS_ST_EMPTY_EV   0
`define SCS_ST_DONE_EV    1
`define SCS_ST_EMPTY      8
`define SCS_ST_EN         16
`define SCS_ST_ACT        17
`define SCS_CFG_HOLD      3
`define SCS_CFG_DIV_LSB   8
`define SCS_CFG_DLY_LSB   24
`define SCS_TXD_CS_LSB    16
`define SCS_DIV_RST       8'h01
`define SCS_DLY_RST       8'h00
`define SCS_WORD_BITS     8
`endif

// ---- scs_pkg.sv ----
package scs_pkg;
  typedef enum logic [1:0] {SCS_IDLE, SCS_SHIFT, SCS_GAP} scs_state_t;
endpackage : scs_pkg

// ---- scs_slave_model.sv ----
`timescale 1ns/10ps
module scs_slave_model #(
  parameter logic [7:0] REPLY = 8'hC5
) (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh;
  int         cnt;
  initial begin
    miso = 1'b0;
    got  = 8'h00;
    sh   = 8'h00;
    cnt  = 0;
  end
  // new frame, first bit ready before the first rise
  always @(negedge sel_n) begin
    cnt  = 0;
    miso = REPLY[7];
  end
  // sample on rise, msb first
  always @(posedge sck) begin
    if (!sel_n) begin
      sh = {sh[6:0], mosi};
      cnt++;
      if (cnt % 8 == 0) got = sh;
    end
  end
  always @(negedge sck) begin
    if (!sel_n) miso = REPLY[7 - cnt % 8];
  end
  // released line keeps no stale level
  always @(posedge sel_n) miso = ~miso;
endmodule : scs_slave_model

// ---- test_spi_chip_select_hold_control.sv ----
`timescale 1ns/10ps
`include "scs_map.svh"
module test_spi_chip_select_hold_control;
  localparam logic [31:0] SMSK = 32'h0003_0100;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        sck;
  logic        sck_oe;
  logic        mosi;
  logic        mosi_oe;
  logic        miso;
  logic [3:0]  cs_n;
  logic        cs_oe;
  logic [7:0]  got;
  logic [31:0] rd;
  logic        err;
  logic        cs0_prev;
  int          rises;
  int          num_errors;
  int          checks;

  scs_spi_ctrl #(.NCS(4)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sck_o(sck), .sck_oe(sck_oe),
    .mosi_o(mosi), .mosi_oe(mosi_oe), .miso_i(miso),
    .cs_n_o(cs_n), .cs_oe(cs_oe));
  scs_slave_model slv_u (.sck(sck), .mosi(mosi), .sel_n(&cs_n),
    .miso(miso), .got(got));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // counts releases of select 0
  always @(negedge sys_clk) begin
    cs0_prev <= cs_n[0];
    if (cs_n[0] && !cs0_prev) rises <= rises + 1;
  end

  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) fail($sformatf("got %h exp %h", g, e));
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (n == 9) fail("no ready");
    rd  = prdata;
    err = pslverr;
    @(posedge sys_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic st(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `SCS_ADDR_STAT, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 60);
    if (n == 60) fail("status wait");
  endtask : st
  task automatic tx(input logic [1:0] c, input logic [7:0] v);
    apb(1'b1, `SCS_ADDR_TXD, {14'h0, c, 8'h00, v});
  endtask : tx
  task automatic finish_test();
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(50 * 20000);
    fail("timeout");
    finish_test();
  end
  initial begin
    sys_rst    = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    cs0_prev   = 1'b1;
    rises      = 0;
    num_errors = 0;
    checks     = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, `SCS_ADDR_STAT, 32'h0);
    chk(rd & SMSK, 32'h0000_0100);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `SCS_ADDR_CTL, 32'h3);
    apb(1'b0, `SCS_ADDR_STAT, 32'h0);
    chk(rd & SMSK, 32'h0000_0100);
    apb(1'b1, `SCS_ADDR_CTL, 32'h1);
    apb(1'b1, `SCS_ADDR_CTL, 32'h0);
    apb(1'b0, `SCS_ADDR_STAT, 32'h0);
    chk(rd & SMSK, 32'h0001_0100);
    apb(1'b1, `SCS_ADDR_CFG, 32'h0200_0400);
    apb(1'b1, `SCS_ADDR_CFG + 8'h04, 32'h0000_0408);
    // reload while shifting on the same select
    tx(2'd0, 8'hA5);
    st(`SCS_ST_EMPTY);
    tx(2'd0, 8'hC3);
    st(`SCS_ST_DONE_EV);
    st(`SCS_ST_DONE_EV);
    repeat (4) @(posedge sys_clk);
    chk(32'(rises), 32'd1);
    chk({24'h0, got}, 32'hC3);
    apb(1'b0, `SCS_ADDR_RXD, 32'h0);
    chk(rd & 32'hFF, 32'hC5);
    // interrupt raised, cleared, masked
    apb(1'b1, `SCS_ADDR_MASK, 32'h1);
    tx(2'd0, 8'h77);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `SCS_ADDR_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    st(`SCS_ST_DONE_EV);
    apb(1'b1, `SCS_ADDR_MASK, 32'h0);
    // held select, then another select, then final word
    tx(2'd1, 8'h3C);
    st(`SCS_ST_DONE_EV);
    repeat (20) @(posedge sys_clk);
    chk({28'h0, cs_n}, 32'hD);
    tx(2'd0, 8'h11);
    st(`SCS_ST_DONE_EV);
    repeat (4) @(posedge sys_clk);
    chk({28'h0, cs_n}, 32'hF);
    tx(2'd1, 8'h5A);
    apb(1'b1, `SCS_ADDR_CTL, 32'h0100_0000);
    st(`SCS_ST_DONE_EV);
    repeat (4) @(posedge sys_clk);
    chk({28'h0, cs_n}, 32'hF);
    chk({24'h0, got}, 32'h5A);
    // disable with a word still pending
    tx(2'd0, 8'h96);
    st(`SCS_ST_EMPTY);
    tx(2'd0, 8'h69);
    apb(1'b1, `SCS_ADDR_CTL, 32'h2);
    st(`SCS_ST_DONE_EV);
    repeat (80) @(posedge sys_clk);
    chk({24'h0, got}, 32'h96);
    chk({29'h0, sck_oe, mosi_oe, cs_oe}, 32'h0);
    apb(1'b0, `SCS_ADDR_STAT, 32'h0);
    chk(rd & SMSK, 32'h0);
    finish_test();
  end
endmodule : test_spi_chip_select_hold_control
